// [hld_pkg.sv]
// Purpose: Shared types and constants for the heater low-side driver control.
// Assumes: A 25 MHz ref_clk.
// Notes:   Filter and mask times are held in ns and turned into cycle counts.
package hld_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int NUM_CHANNELS  = 2;

   // Overcurrent filter window, 1.5 us to 2.5 us.
   localparam int OVC_FILT_MIN_NS = 1500;
   localparam int OVC_FILT_MAX_NS = 2500;
   // Off-state diagnosis filter window, 7 us to 13 us.
   localparam int DIAG_FILT_MIN_NS = 7000;
   localparam int DIAG_FILT_MAX_NS = 13000;
   // Diagnosis mask after switch-off, 300 us to 500 us.
   localparam int MASK_MIN_NS = 300000;
   localparam int MASK_MAX_NS = 500000;

   // Least times round up so the hardware never fires early.
   localparam int OVC_FILT_CYC =
      (OVC_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIAG_FILT_CYC =
      (DIAG_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MASK_CYC =
      (MASK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int CNT_W = 14;

   // Status word layout per channel: bit 0 overcurrent, 1 open load,
   // 2 short to ground.
   localparam int ST_OVC_BIT = 0;
   localparam int ST_OL_BIT  = 1;
   localparam int ST_SG_BIT  = 2;
   localparam int ST_W       = 3;
   localparam logic [ST_W-1:0] ST_RESET = 3'h0;

   // Raw analog comparator flags for one channel.
   typedef struct packed {
      logic ovc;
      logic open_load;
      logic short_gnd;
   } hld_sense_t;

   typedef struct packed {
      logic ovc;
      logic open_load;
      logic short_gnd;
   } hld_fault_t;

endpackage

// [hld_filter.sv]
// Purpose: Persistence filter; a level must hold for LEN cycles in a row.
// Assumes: Input already synchronous to ref_clk.
// Notes:   Any drop of the input restarts the count.
`timescale 1ns/1ps
module hld_filter #(
   parameter int LEN = 38
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Level in, qualified level out
   input  wire logic level,
   output logic      hit_q
);

   localparam int W = $clog2(LEN + 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         hit_d;

   // The count must fit the counter width that the package allows.
   if (LEN < 1 || LEN > 2**hld_pkg::CNT_W - 1) begin : g_bad_len
      $error("hld_filter LEN out of range");
   end

   always_comb begin
      cnt_d = '0;
      hit_d = 1'b0;
      if (level) begin
         if (cnt_q >= W'(LEN - 1)) begin
            cnt_d = W'(LEN - 1);
            hit_d = 1'b1;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         hit_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         hit_q <= hit_d;
      end
   end

endmodule

// [hld_ctrl.sv]
// Purpose: Control and diagnosis for two protected low-side heater drivers.
// Assumes: Command bits arrive on ref_clk from the serial port logic;
//          parallel inputs and sense flags are asynchronous pins.
// Notes:   Faults latch until the host clears them with a clear pulse.
// Notes on behaviour
// R1: Two independent channels each carry overcurrent protection and diagnosis.
// R2: A channel turns on only while its command bit and parallel input are high.
// R3: A confirmed overcurrent switches the channel off on the fast path.
// R4: Overcurrent counts only after it persists for the 1.5 us filter time.
// R5: Off-state open load and short to ground need 7 us of persistence.
// R6: Off-state diagnosis is masked for 300 us after each switch-off.
// R7: Reset or global disable forces both off; faults latch in a status word.
`timescale 1ns/1ps
module hld_ctrl #(
   // Filter and mask lengths, counted in ref_clk cycles.
   parameter int OVC_LEN  = hld_pkg::OVC_FILT_CYC,
   parameter int DIAG_LEN = hld_pkg::DIAG_FILT_CYC,
   parameter int MASK_LEN = hld_pkg::MASK_CYC
) (
   // Clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   // Host command, synchronous to ref_clk
   input  wire logic [1:0]                   heater_cmd,
   input  wire logic                         global_output_disable,
   input  wire logic                         diag_clear,
   // Parallel input pins
   input  wire logic                         heater_par_input_a,
   input  wire logic                         heater_par_input_b,
   // Analog sense flags, asynchronous
   input  wire hld_pkg::hld_sense_t          sense_a,
   input  wire hld_pkg::hld_sense_t          sense_b,
   // Driver gates
   output logic                              heater_output_a,
   output logic                              heater_output_b,
   output logic [1:0]                        fast_off_q,
   // Diagnostic status word
   output logic [2*hld_pkg::ST_W-1:0]        diag_status_q
);

   localparam int MW = $clog2(MASK_LEN + 1);

   // The port list carries exactly two channels and the filters count in
   // a fixed width, so other settings cannot be served.
   if (hld_pkg::NUM_CHANNELS != 2) begin : g_bad_chan
      $error("hld_ctrl serves exactly two channels");
   end
   if (OVC_LEN < 1 || OVC_LEN > 2**hld_pkg::CNT_W - 1) begin : g_bad_ovc
      $error("hld_ctrl OVC_LEN out of range");
   end
   if (DIAG_LEN < 1 || DIAG_LEN > 2**hld_pkg::CNT_W - 1) begin : g_bad_diag
      $error("hld_ctrl DIAG_LEN out of range");
   end
   if (MASK_LEN < 1) begin : g_bad_mask
      $error("hld_ctrl MASK_LEN out of range");
   end

   logic [1:0] par_s1_q;
   logic [1:0] par_s2_q;
   logic [2:0] sen_s1_q [2];
   logic [2:0] sen_s2_q [2];
   logic [1:0] on_q;
   logic [1:0] on_d;
   logic [1:0] fast_off_d;
   logic [MW-1:0] mask_q [2];
   logic [MW-1:0] mask_d [2];
   logic [2*hld_pkg::ST_W-1:0] diag_status_d;
   logic [1:0] ovc_hit;
   logic [1:0] ol_hit;
   logic [1:0] sg_hit;
   logic [1:0] ovc_lock_q;
   logic [1:0] ovc_lock_d;

   // Bit position of one fault flag of one channel in the status word.
   function automatic int st_pos(input int ch, input int fault);
      return ch * hld_pkg::ST_W + fault;
   endfunction

   // A channel drives only while command, pin, no global disable and no
   // overcurrent lock all agree.
   function automatic logic gate_on(input logic cmd, input logic pin,
                                    input logic dis, input logic lock);
      return cmd && pin // R2
             && !dis && !lock; // R7
   endfunction

   // Pins pass two flops before any logic reads them.
   // Command bits come from logic on ref_clk and skip this stage, so a pin
   // change reaches the gate two cycles later than a command change.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         par_s1_q <= 2'h0;
         par_s2_q <= 2'h0;
         for (int i = 0; i < 2; i++) begin
            sen_s1_q[i] <= 3'h0;
            sen_s2_q[i] <= 3'h0;
         end
      end else begin
         par_s1_q    <= {heater_par_input_b, heater_par_input_a};
         par_s2_q    <= par_s1_q;
         sen_s1_q[0] <= sense_a;
         sen_s1_q[1] <= sense_b;
         sen_s2_q[0] <= sen_s1_q[0];
         sen_s2_q[1] <= sen_s1_q[1];
      end
   end

   // One filter set per channel.
   for (genvar c = 0; c < 2; c++) begin : g_ch // R1
      logic off_diag;
      assign off_diag = !on_q[c] && (mask_q[c] == '0); // R6
      // The overcurrent filter runs only while the channel is on, so a
      // short present at turn-on still needs the full filter time.
      hld_filter #(.LEN(OVC_LEN)) u_ovc ( // R4
         .ref_clk (ref_clk),
         .rst     (rst),
         .level   (sen_s2_q[c][2] && on_q[c]),
         .hit_q   (ovc_hit[c])
      );
      hld_filter #(.LEN(DIAG_LEN)) u_ol ( // R5
         .ref_clk (ref_clk),
         .rst     (rst),
         .level   (sen_s2_q[c][1] && off_diag),
         .hit_q   (ol_hit[c])
      );
      hld_filter #(.LEN(DIAG_LEN)) u_sg ( // R5
         .ref_clk (ref_clk),
         .rst     (rst),
         .level   (sen_s2_q[c][0] && off_diag),
         .hit_q   (sg_hit[c])
      );
   end

   // Channel control: gate, fast turn-off and overcurrent lock.
   always_comb begin
      on_d       = 2'h0;
      fast_off_d = 2'h0;
      ovc_lock_d = ovc_lock_q;
      for (int c = 0; c < 2; c++) begin
         // The lock holds the channel off after overcurrent until the command
         // bit or the parallel input drops, so it cannot chatter into the short.
         if (!heater_cmd[c] || !par_s2_q[c]) begin
            ovc_lock_d[c] = 1'b0;
         end
         if (ovc_hit[c]) begin
            ovc_lock_d[c] = 1'b1; // R3
         end
         on_d[c] = gate_on(heater_cmd[c], par_s2_q[c], // R2
                           global_output_disable, ovc_lock_d[c]); // R7
         fast_off_d[c] = ovc_hit[c] || (ovc_lock_q[c] && !on_d[c]); // R3
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin // R7
         on_q            <= 2'h0;
         fast_off_q      <= 2'h0;
         ovc_lock_q      <= 2'h0;
         heater_output_a <= 1'b0;
         heater_output_b <= 1'b0;
      end else begin
         on_q            <= on_d;
         fast_off_q      <= fast_off_d;
         ovc_lock_q      <= ovc_lock_d;
         heater_output_a <= on_d[0];
         heater_output_b <= on_d[1];
      end
   end

   // Mask counters restart on every switch-off; they start at zero after
   // reset, so a channel that never ran is diagnosed at once.
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         mask_d[c] = mask_q[c];
         if (on_q[c] && !on_d[c]) begin
            mask_d[c] = MW'(MASK_LEN); // R6
         end else if (on_d[c]) begin
            mask_d[c] = '0;
         end else if (mask_q[c] != '0) begin
            mask_d[c] = mask_q[c] - MW'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mask_q[0] <= '0;
         mask_q[1] <= '0;
      end else begin
         mask_q[0] <= mask_d[0];
         mask_q[1] <= mask_d[1];
      end
   end

   // Status word: clear first, so a fault in the clear cycle still latches
   // and the host never loses an event that it has not read yet.
   always_comb begin
      diag_status_d = diag_status_q;
      for (int c = 0; c < 2; c++) begin
         if (diag_clear) begin
            diag_status_d[st_pos(c, 0) +: hld_pkg::ST_W] =
               hld_pkg::ST_RESET;
         end
         if (ovc_hit[c]) begin
            diag_status_d[st_pos(c, hld_pkg::ST_OVC_BIT)] = 1'b1; // R7
         end
         if (ol_hit[c]) begin
            diag_status_d[st_pos(c, hld_pkg::ST_OL_BIT)] = 1'b1; // R7
         end
         if (sg_hit[c]) begin
            diag_status_d[st_pos(c, hld_pkg::ST_SG_BIT)] = 1'b1; // R7
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin // R7
         diag_status_q <= {2{hld_pkg::ST_RESET}};
      end else begin
         diag_status_q <= diag_status_d;
      end
   end

endmodule

// [hld_ctrl_asserts.sv]
// Purpose: Port assertions for hld_ctrl.
// Assumes: Latencies as handed over by the designer.
// Notes:   Helper counters saturate at 14 bits.
`timescale 1ns/1ps
module hld_ctrl_chk (
   // Clock and reset
   input wire logic                       ref_clk,
   input wire logic                       rst,
   // Requests
   input wire logic [1:0]                 heater_cmd,
   input wire logic                       global_output_disable,
   input wire logic                       heater_par_input_a,
   input wire hld_pkg::hld_sense_t        sense_a,
   // Results
   input wire logic                       heater_output_a,
   input wire logic                       heater_output_b,
   input wire logic [1:0]                 fast_off_q,
   input wire logic [2*hld_pkg::ST_W-1:0] diag_status_q
);
   logic [13:0] ovc_q, ol_q, off_q;
   // Off time starts saturated, so nothing is assumed masked before turn-on.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ovc_q <= 14'h0000;
         ol_q <= 14'h0000;
         off_q <= 14'h3fff;
      end else begin
         ovc_q <= sense_a.ovc ? ovc_q + {13'h0000, ~&ovc_q} : 14'h0000;
         ol_q <= sense_a.open_load ? ol_q + {13'h0000, ~&ol_q} : 14'h0000;
         off_q <= heater_output_a ? 14'h0000 : off_q + {13'h0000, ~&off_q};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_trip; $rose(fast_off_q[0]); endsequence
   sequence s_ol; $rose(diag_status_q[1]); endsequence
   property p_gate;
      heater_output_a |-> $past(heater_cmd[0]) && $past(heater_par_input_a, 3);
   endproperty
   property p_chan_b; heater_output_b |-> $past(heater_cmd[1]); endproperty
   property p_trip; s_trip |-> !heater_output_a && diag_status_q[0];
   endproperty
   property p_ovc; $rose(diag_status_q[0]) |-> ovc_q >= hld_pkg::OVC_FILT_CYC;
   endproperty
   property p_filt; s_ol |-> ol_q >= hld_pkg::DIAG_FILT_CYC; endproperty
   property p_mask; s_ol |-> off_q >= hld_pkg::MASK_CYC; endproperty
   property p_dis;
      global_output_disable |=> !heater_output_a && !heater_output_b;
   endproperty
   a_gate: assert property (p_gate) else $error("a on without both");
   a_chan_b: assert property (p_chan_b) else $error("b on, no cmd");
   a_trip: assert property (p_trip) else $error("trip left a on");
   a_ovc: assert property (p_ovc) else $error("ovc trip too soon");
   a_filt: assert property (p_filt) else $error("diag too soon");
   a_mask: assert property (p_mask) else $error("diag in mask");
   a_dis: assert property (p_dis) else $error("disable ignored");
endmodule
bind hld_ctrl hld_ctrl_chk i_hld_ctrl_chk (.ref_clk, .rst, .heater_cmd,
   .global_output_disable, .heater_par_input_a, .sense_a,
   .heater_output_a, .heater_output_b, .fast_off_q, .diag_status_q);

// [hld_host_model.sv]
// Purpose: Controller side: command bits and parallel input pins.
// Assumes: Requests from the bench arrive on ref_clk.
// Notes:   Command and pin are separate so a split request can be made.
`timescale 1ns/1ps
module hld_host_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Requests
   input  wire logic [1:0] cmd_req,
   input  wire logic [1:0] pin_req,
   // Lines to the device
   output logic [1:0]      heater_cmd,
   output logic            heater_par_input_a,
   output logic            heater_par_input_b
);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         {heater_cmd, heater_par_input_b, heater_par_input_a} <= 4'h0;
      else begin
         heater_cmd <= cmd_req;
         {heater_par_input_b, heater_par_input_a} <= pin_req;
      end
   end
endmodule

// [test_heater_lowside_driver_ctrl.sv]
// Purpose: Bench for hld_ctrl.
// Assumes: 25 MHz ref_clk.
// Notes:   Every wait is bounded.
`timescale 1ns/1ps
module test_heater_lowside_driver_ctrl;
   logic ref_clk, rst, dis, clr, pa, pb, oa, ob;
   logic [1:0] cmd_req, pin_req, hc, fo;
   logic [5:0] st;
   hld_pkg::hld_sense_t sa, sb;
   int bad_count = 0, checks_done = 0, n;
   hld_host_model i_hld_host_model (.ref_clk, .rst, .cmd_req, .pin_req,
      .heater_cmd(hc), .heater_par_input_a(pa), .heater_par_input_b(pb));
   hld_ctrl i_hld_ctrl (.ref_clk, .rst, .heater_cmd(hc),
      .global_output_disable(dis), .diag_clear(clr), .heater_par_input_a(pa),
      .heater_par_input_b(pb), .sense_a(sa), .sense_b(sb),
      .heater_output_a(oa), .heater_output_b(ob), .fast_off_q(fo),
      .diag_status_q(st));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic go(logic [1:0] c, p, dc, logic [5:0] s, int k);
      @(posedge ref_clk);
      cmd_req <= c;
      pin_req <= p;
      {dis, clr} <= dc;
      {sb, sa} <= s;
      repeat (k) @(negedge ref_clk);
   endtask
   task automatic wait_st(int b);
      n = 0;
      while (st[b] !== 1'b1) begin
         @(negedge ref_clk);
         n++;
         if (n > 14000) begin
            bad_count++;
            conclude();
         end
      end
   endtask
   task automatic t_gate();
      go(2'h3, 2'h0, 2'h0, 6'h00, 6);
      check("cmd only", {ob, oa}, 8'h00);
      go(2'h0, 2'h3, 2'h0, 6'h00, 6);
      check("pin only", {ob, oa}, 8'h00);
      go(2'h1, 2'h3, 2'h0, 6'h00, 6);
      check("a alone", {ob, oa}, 8'h01);
      go(2'h1, 2'h3, 2'h2, 6'h00, 2);
      check("disable", oa, 8'h00);
   endtask
   task automatic t_ovc();
      go(2'h3, 2'h3, 2'h0, 6'h00, 6);
      go(2'h3, 2'h3, 2'h0, 6'h04, 30);
      go(2'h3, 2'h3, 2'h0, 6'h00, 4);
      check("glitch", {st, ob, oa}, 8'h03);
      go(2'h3, 2'h3, 2'h0, 6'h04, 0);
      wait_st(0);
      check("ovc time", n >= 38 && n <= 65, 8'h01);
      check("trip", {fo, ob, oa}, 8'h06);
      go(2'h0, 2'h0, 2'h0, 6'h00, 4);
      check("fast off released", fo, 8'h00);
   endtask
   task automatic t_diag();
      go(2'h3, 2'h3, 2'h0, 6'h00, 6);
      go(2'h0, 2'h0, 2'h0, 6'h0a, 0);
      wait_st(1);
      check("mask", n >= 7675 && n <= 12830, 8'h01);
      wait_st(5);
      check("b short", n < 400, 8'h01);
      go(2'h0, 2'h0, 2'h1, 6'h0a, 0);
      go(2'h0, 2'h0, 2'h0, 6'h0a, 2);
      check("set wins", st, 8'h22);
      go(2'h0, 2'h0, 2'h0, 6'h00, 4);
      go(2'h0, 2'h0, 2'h1, 6'h00, 0);
      go(2'h0, 2'h0, 2'h0, 6'h00, 2);
      check("cleared", st, 8'h00);
   endtask
   task automatic t_reset();
      go(2'h3, 2'h3, 2'h0, 6'h00, 6);
      check("both on", {st, ob, oa}, 8'h07);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(negedge ref_clk);
      check("mid reset", {st, ob, oa}, 8'h00);
      check("mid reset fast off", fo, 8'h00);
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (6) @(negedge ref_clk);
      check("after reset", {st, ob, oa}, 8'h03);
   endtask
   initial begin
      {dis, clr, cmd_req, pin_req, sa, sb} = 12'h000;
      rst = 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check("reset", {st, ob, oa}, 8'h00);
      t_gate();
      t_ovc();
      t_reset();
      t_diag();
      conclude();
   end
endmodule
